//--- sim/dpl_ctrl_tb.sv
// Self-checking bench for the parallel converter write controller.
`timescale 1ns/1ps
module dpl_ctrl_tb;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic err;
   logic [11:0] in_word;
   logic [9:0] code;
   dpl_pkg::dpl_pins_s pins;
   int bad_count = 0, total_checks = 0, spurious = 0, cyc = 0;
   logic [9:0] codes [4] = '{10'h2A5, 10'h3FF, 10'h155, 10'h001};
   logic [31:0] ctls [4] = '{32'h01, 32'h03, 32'h11, 32'h03};
   dpl_ctrl u_dpl_ctrl (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .pins(pins));
   dpl_dac_model u_dpl_dac_model (.pins(pins), .in_word(in_word), .code(code));
   // Clock at 40 MHz.
   initial begin
      pclk = 1'b0;
      forever #12.5 pclk = ~pclk;
   end
   // A hang is cut short well beyond the expected run length.
   always @(posedge pclk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         bad_count++;
         stop_test();
      end
   end
   // The converter output may only move while the load strobe is low or during clear.
   always @(code) if (presetn === 1'b1 && pins.transfer_strobe_n && pins.latch_zero_n) spurious++;
   task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      total_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
      end
   endtask : chk
   // One APB transfer; request held until pready is seen, then released.
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask : apb
   task automatic wait_idle();
      int n;
      n = 0;
      do begin
         apb(1'b0, dpl_pkg::STAT_OFS, 32'h0);
         n++;
      end while (rd[0] !== 1'b0 && n < 200);
      chk("idle", 32'h0, {31'h0, rd[0]});
   endtask : wait_idle
   task automatic stop_test();
      $display("checks %0d mismatches %0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask : stop_test
   // Main sequence.
   initial begin
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      repeat (8) @(posedge pclk);
      chk("zero_pin", 32'h0, {31'h0, pins.latch_zero_n});
      chk("por_code", 32'h0, {22'h0, code});
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      apb(1'b0, dpl_pkg::CTRL_OFS, 32'h0);
      chk("ctrl_rst", 32'h0, rd);
      apb(1'b0, dpl_pkg::TIME_OFS, 32'h0);
      chk("time_rst", 32'h2, rd);
      apb(1'b0, 8'h10, 32'h0);
      chk("unmapped_err", 32'h1, {31'h0, err});
      chk("unmapped_data", 32'h0, rd);
      // Both loading modes untied, and byte mode with a tied load strobe; last case at the shortest phase.
      for (int i = 0; i < 4; i++) begin
         if (i == 3) begin
            apb(1'b1, dpl_pkg::TIME_OFS, 32'h0);
            apb(1'b0, dpl_pkg::TIME_OFS, 32'h0);
            chk("time_min", 32'h2, rd);
         end
         apb(1'b1, dpl_pkg::DATA_OFS, {22'h0, codes[i]});
         apb(1'b1, dpl_pkg::CTRL_OFS, ctls[i]);
         wait_idle();
         chk("in_word", {20'h0, codes[i], 2'b00}, {20'h0, in_word});
         chk("dac_code", {22'h0, codes[i]}, {22'h0, code});
      end
      // Data written while busy must be ignored.
      apb(1'b1, dpl_pkg::TIME_OFS, 32'h2);
      apb(1'b1, dpl_pkg::DATA_OFS, 32'h0F0);
      apb(1'b1, dpl_pkg::CTRL_OFS, 32'h01);
      apb(1'b1, dpl_pkg::DATA_OFS, 32'h30F);
      wait_idle();
      chk("busy_code", 32'h0F0, {22'h0, code});
      // Clear, then a bare load without select.
      apb(1'b1, dpl_pkg::CTRL_OFS, 32'h08);
      repeat (2) @(posedge pclk);
      chk("clear_code", 32'h0, {22'h0, code});
      apb(1'b1, dpl_pkg::CTRL_OFS, 32'h04);
      repeat (2) @(posedge pclk);
      chk("xfer_code", 32'h0F0, {22'h0, code});
      chk("xfer_cs", 32'h1, {31'h0, pins.cs_n});
      apb(1'b1, dpl_pkg::CTRL_OFS, 32'h0);
      chk("spurious", 32'h0, spurious);
      stop_test();
   end
endmodule : dpl_ctrl_tb

//--- sim/dpl_dac_model.sv
// Behavioural model of the converter's input latch and converter latch.
`timescale 1ns/1ps
module dpl_dac_model (
   input wire dpl_pkg::dpl_pins_s pins,
   output logic [11:0] in_word,
   output logic [9:0] code
);
   logic wr_sel;
   // Strobe only counts while the chip is selected.
   assign wr_sel = !pins.cs_n && !pins.wr_n;
   // Power-up state of both latches.
   initial begin
      in_word = 12'h000;
      code = 10'h000;
   end
   // Input latches are level sensitive, so data follows the bus while selected with the write strobe low.
   always @* begin
      if (wr_sel) begin
         case (pins.addr)
            2'h3: in_word[11:8] = pins.data[3:0];
            2'h2: in_word[3:0] = pins.data[3:0];
            2'h1: in_word[7:4] = pins.data[7:4];
            default: in_word[7:0] = pins.data;
         endcase
      end
   end
   // Clear wins over load; the converter latch does not follow while an eight-bit write is active.
   always @* begin
      if (!pins.latch_zero_n) begin
         code = 10'h000;
      end else if (!pins.transfer_strobe_n && !(wr_sel && pins.addr == 2'h0)) begin
         code = in_word[11:2];
      end
   end
endmodule : dpl_dac_model

//--- src/dpl_ctrl.sv
// Host controller that writes a 10-bit code into a double-buffered parallel DAC over its latch pins.
`timescale 1ns/1ps
module dpl_ctrl (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   output dpl_pkg::dpl_pins_s pins
);
   logic go;
   logic [4:0] ctrl;
   logic [9:0] code;
   logic [7:0] width;
   dpl_pkg::dpl_state_e state_q, state_d;
   logic [1:0] step_q;
   logic [7:0] cnt_q;
   logic [11:0] word_q;
   logic nib_mode_q;
   logic tie_load_q;
   logic busy;
   logic cnt_done;
   logic last_step;
   logic [1:0] addr_sel;
   logic [7:0] data_sel;
   dpl_pkg::dpl_pins_s pins_q;

   dpl_regs u_regs (
      .pclk(pclk),
      .presetn(presetn),
      .psel(psel),
      .penable(penable),
      .pwrite(pwrite),
      .paddr(paddr),
      .pwdata(pwdata),
      .prdata(prdata),
      .pready(pready),
      .pslverr(pslverr),
      .busy(busy),
      .go(go),
      .ctrl(ctrl),
      .code(code),
      .width(width)
   );

   // Nibble picker shared by all three write steps.
   function automatic logic [3:0] nib(input logic [11:0] w, input int idx);
      nib = w[idx*dpl_pkg::NIB_W +: dpl_pkg::NIB_W];
   endfunction : nib

   // Step order: nibble mode is low, mid, high; byte mode is low+mid then high.
   assign busy = (state_q != dpl_pkg::ST_IDLE);
   assign cnt_done = (cnt_q <= 8'h01);
   assign last_step = nib_mode_q ? (step_q == 2'h2) : (step_q == 2'h1);
   // Address lines chosen per step.
   assign addr_sel = last_step ? dpl_pkg::ADDR_HIGH :
                     !nib_mode_q ? dpl_pkg::ADDR_LOWMID :
                     (step_q == 2'h0) ? dpl_pkg::ADDR_LOW : dpl_pkg::ADDR_MID;
   // Shared bus: nibble mode repeats one nibble on both halves.
   assign data_sel = last_step ? {nib(word_q, 2), nib(word_q, 2)} :
                     !nib_mode_q ? {nib(word_q, 1), nib(word_q, 0)} :
                     (step_q == 2'h0) ? {nib(word_q, 0), nib(word_q, 0)} : {nib(word_q, 1), nib(word_q, 1)};

   // Sequencer next state.
   always_comb begin
      state_d = state_q;
      unique case (state_q)
         dpl_pkg::ST_IDLE: if (go) state_d = dpl_pkg::ST_SETUP;
         dpl_pkg::ST_SETUP: if (cnt_done) state_d = dpl_pkg::ST_STROBE;
         dpl_pkg::ST_STROBE: if (cnt_done) state_d = dpl_pkg::ST_HOLD;
         dpl_pkg::ST_HOLD: begin
            if (cnt_done) state_d = !last_step ? dpl_pkg::ST_SETUP :
                                    tie_load_q ? dpl_pkg::ST_IDLE : dpl_pkg::ST_XFER;
         end
         dpl_pkg::ST_XFER: if (cnt_done) state_d = dpl_pkg::ST_IDLE;
      endcase
   end

   // State, step and width counter; each phase lasts width cycles, at least 45 ns.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_q <= dpl_pkg::ST_IDLE;
         step_q <= 2'h0;
         cnt_q <= dpl_pkg::TIME_RST;
      end else begin
         state_q <= state_d;
         cnt_q <= (state_d != state_q) ? width : cnt_q - 8'h01;
         if (state_q == dpl_pkg::ST_IDLE) step_q <= 2'h0;
         else if (state_q == dpl_pkg::ST_HOLD && cnt_done) step_q <= step_q + 2'h1;
      end
   end

   // Word capture at go; sub-LSBs are forced to zero.
   // Mode and tie come from the write that raises go, because the control
   // register still shows its old value in that cycle.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         word_q <= 12'h000;
         nib_mode_q <= 1'b0;
         tie_load_q <= 1'b0;
      end else if (go) begin
         word_q <= {code, 2'b00};
         nib_mode_q <= pwdata[dpl_pkg::CTRL_MODE_BIT];
         tie_load_q <= pwdata[dpl_pkg::CTRL_TIE_BIT];
      end
   end

   // Pin register: select frames the strobe with setup and hold so the
   // transparent latch closes on stable data.
   // Load held low makes the final high-nibble write update at once.
   // Clear is driven straight from software, never gated by select.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pins_q <= '{cs_n: 1'b1, wr_n: 1'b1, addr: 2'h0, data: 8'h00,
                     transfer_strobe_n: 1'b1, latch_zero_n: 1'b0};
      end else begin
         pins_q.cs_n <= !(state_d inside {dpl_pkg::ST_SETUP, dpl_pkg::ST_STROBE, dpl_pkg::ST_HOLD});
         pins_q.wr_n <= (state_d != dpl_pkg::ST_STROBE);
         if (state_d == dpl_pkg::ST_SETUP) pins_q.addr <= addr_sel;
         if (state_d == dpl_pkg::ST_SETUP) pins_q.data <= data_sel;
         // The separate strobe needs no select.
         // A tied sequence keeps the strobe low to its end even if software drops the bit.
         pins_q.transfer_strobe_n <= !((state_d == dpl_pkg::ST_XFER) || (tie_load_q && busy) ||
                                       ctrl[dpl_pkg::CTRL_TIE_BIT] || ctrl[dpl_pkg::CTRL_XFER_BIT]);
         // Held low out of reset, matching the device's power-on zero.
         pins_q.latch_zero_n <= !ctrl[dpl_pkg::CTRL_ZERO_BIT];
      end
   end
   assign pins = pins_q;

   // Write strobe only ever falls inside a chip-select frame.
   AST_WR_IN_CS: assert property (@(posedge pclk) disable iff (!presetn) !pins.wr_n |-> !pins.cs_n)
      else $error("write strobe low outside chip select");
   // Strobe low width is the programmed width, at least two cycles by default.
   AST_WR_WIDTH: assert property (@(posedge pclk) disable iff (!presetn)
      $fell(pins.wr_n) |-> !pins.wr_n [*2])
      else $error("write strobe shorter than 45 ns");
   // Address and data never move while the strobe is low.
   AST_STABLE: assert property (@(posedge pclk) disable iff (!presetn)
      !pins.wr_n && !$past(pins.wr_n) |-> $stable(pins.addr) && $stable(pins.data))
      else $error("bus changed under write strobe");
   // Sub-LSBs are zero whenever the low nibble is written.
   AST_SUBLSB: assert property (@(posedge pclk) disable iff (!presetn)
      !pins.wr_n && !pins.addr[0] |-> pins.data[1:0] == 2'b00)
      else $error("sub-LSB bits not zero");
   // High nibble write carries bits six to nine.
   AST_HIGH: assert property (@(posedge pclk) disable iff (!presetn)
      !pins.wr_n && pins.addr == dpl_pkg::ADDR_HIGH |-> pins.data[3:0] == word_q[11:8])
      else $error("high nibble data wrong");
   // Byte write carries low and middle nibbles together.
   AST_BYTE: assert property (@(posedge pclk) disable iff (!presetn)
      !pins.wr_n && pins.addr == dpl_pkg::ADDR_LOWMID |-> pins.data == word_q[7:0])
      else $error("byte write data wrong");
   // Middle nibble write carries bits two to five.
   AST_MID: assert property (@(posedge pclk) disable iff (!presetn)
      !pins.wr_n && pins.addr == dpl_pkg::ADDR_MID |-> pins.data[3:0] == word_q[7:4])
      else $error("middle nibble data wrong");
   // Clear follows the control bit one cycle later.
   AST_ZERO: assert property (@(posedge pclk) disable iff (!presetn)
      1'b1 |=> pins.latch_zero_n == !$past(ctrl[dpl_pkg::CTRL_ZERO_BIT]))
      else $error("clear pin does not follow control");
endmodule : dpl_ctrl

//--- src/dpl_pkg.sv
// Shared constants, register map and carrier types for the parallel DAC write controller.
package dpl_pkg;
   // APB register byte offsets.
   localparam logic [7:0] CTRL_OFS = 8'h00;
   localparam logic [7:0] DATA_OFS = 8'h04;
   localparam logic [7:0] STAT_OFS = 8'h08;
   localparam logic [7:0] TIME_OFS = 8'h0C;
   // Control register fields.
   localparam int CTRL_GO_BIT = 0;
   localparam int CTRL_MODE_BIT = 1;
   localparam int CTRL_XFER_BIT = 2;
   localparam int CTRL_ZERO_BIT = 3;
   localparam int CTRL_TIE_BIT = 4;
   localparam int STAT_BUSY_BIT = 0;
   // Data register: 10-bit code in the low bits.
   localparam int CODE_W = 10;
   localparam int WORD_W = 12;
   localparam int NIB_W = 4;
   // Address line pairs {addr_line_one, addr_line_zero} per nibble choice.
   localparam logic [1:0] ADDR_HIGH = 2'h3;
   localparam logic [1:0] ADDR_LOW = 2'h2;
   localparam logic [1:0] ADDR_MID = 2'h1;
   localparam logic [1:0] ADDR_LOWMID = 2'h0;
   // Strobe widths: 45 ns least, at 40 MHz.
   localparam int STROBE_NS = 45;
   localparam int CLK_PERIOD_NS = 25;
   localparam int STROBE_CYC = (STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [7:0] TIME_RST = 8'(STROBE_CYC);
   localparam logic [31:0] BAD_ADDR_DATA = 32'h0000_0000;
   // Pins toward the converter.
   typedef struct packed {
      logic cs_n;
      logic wr_n;
      logic [1:0] addr;
      logic [7:0] data;
      logic transfer_strobe_n;
      logic latch_zero_n;
   } dpl_pins_s;
   // Phases of one bus cycle toward the converter.
   typedef enum logic [2:0] {ST_IDLE, ST_SETUP, ST_STROBE, ST_HOLD, ST_XFER} dpl_state_e;
endpackage : dpl_pkg

//--- src/dpl_regs.sv
// APB register file for the parallel DAC write controller.
`timescale 1ns/1ps
module dpl_regs (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic busy,
   output logic go,
   output logic [4:0] ctrl,
   output logic [9:0] code,
   output logic [7:0] width
);
   logic [4:0] ctrl_q;
   logic [9:0] code_q;
   logic [7:0] width_q;
   logic [31:0] rdata_d;
   logic wr_ok;
   logic bad;
   // Decode; every access answers in its first access cycle.
   assign wr_ok = psel & penable & pwrite;
   assign bad = (paddr != dpl_pkg::CTRL_OFS) && (paddr != dpl_pkg::DATA_OFS) &&
                (paddr != dpl_pkg::STAT_OFS) && (paddr != dpl_pkg::TIME_OFS);
   assign pready = 1'b1;
   assign pslverr = psel & penable & bad;
   assign go = wr_ok & (paddr == dpl_pkg::CTRL_OFS) & pwdata[dpl_pkg::CTRL_GO_BIT] & ~busy;
   assign ctrl = ctrl_q;
   assign code = code_q;
   assign width = width_q;
   assign rdata_d = (paddr == dpl_pkg::CTRL_OFS) ? {27'h0, ctrl_q} :
                    (paddr == dpl_pkg::DATA_OFS) ? {22'h0, code_q} :
                    (paddr == dpl_pkg::STAT_OFS) ? {31'h0, busy} :
                    (paddr == dpl_pkg::TIME_OFS) ? {24'h0, width_q} : dpl_pkg::BAD_ADDR_DATA;
   // Writes take effect only at the completing edge; go is self-clearing.
   // A width below the 45 ns floor is raised to it, so no strobe can come out too short.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_q <= 5'h00;
         code_q <= 10'h000;
         width_q <= dpl_pkg::TIME_RST;
         prdata <= 32'h0000_0000;
      end else begin
         if (wr_ok && paddr == dpl_pkg::CTRL_OFS) ctrl_q <= {pwdata[4:1], 1'b0};
         if (wr_ok && paddr == dpl_pkg::DATA_OFS && !busy) code_q <= pwdata[9:0];
         if (wr_ok && paddr == dpl_pkg::TIME_OFS) begin
            width_q <= (pwdata[7:0] < dpl_pkg::TIME_RST) ? dpl_pkg::TIME_RST : pwdata[7:0];
         end
         if (psel && !penable && !pwrite) prdata <= rdata_d;
      end
   end
   // A go while busy is dropped; status shows busy from the cycle after go.
   AST_GO_BUSY: assert property (@(posedge pclk) disable iff (!presetn) go |=> busy)
      else $error("busy did not rise after go");
endmodule : dpl_regs
